// ===== verilog/mbws_params.svh
// Purpose: constants of the multi-write request handler
// Assumes: included by every design file that needs them
// Notes: byte offsets count from the slave address byte of a frame
`ifndef MBWS_PARAMS_SVH
`define MBWS_PARAMS_SVH

`define MBWS_FC_WR_REG 8'h06
`define MBWS_FC_WR_COILS 8'h0f
`define MBWS_FC_WR_REGS 8'h10
`define MBWS_OFS_FC 4'h1
`define MBWS_OFS_BCNT 4'h6
`define MBWS_OFS_DATA 4'h7
`define MBWS_ECHO_LEN 4'h8
`define MBWS_HDR_LEN 4'h6
`define MBWS_COILS_PER_BYTE 16'h0008
`define MBWS_RST_REG 16'h0000

`endif

// ===== verilog/mbws_pkg.sv
// Purpose: shared types of the multi-write request handler
// Assumes: nothing beyond the constants header
// Notes: states are one-hot
package mbws_pkg;
    typedef enum logic [3:0] {
        MBWS_IDLE = 4'h1,
        MBWS_RECV = 4'h2,
        MBWS_DROP = 4'h4,
        MBWS_RESP = 4'h8
    } mbws_state_t;
endpackage

// ===== verilog/mbws_wr_if.sv
// Purpose: write strobes from the parser to the storage
// Assumes: one clock for both ends
// Notes: strobes are one-cycle pulses
`timescale 1ns/10ps
interface mbws_wr_if;
    logic coil_we;
    logic [15:0] coil_base;
    logic [7:0] coil_byte;
    logic [3:0] coil_n;
    logic reg_we;
    logic [15:0] reg_idx;
    logic [15:0] reg_val;
    modport src (output coil_we, coil_base, coil_byte, coil_n, reg_we, reg_idx, reg_val);
    modport dst (input coil_we, coil_base, coil_byte, coil_n, reg_we, reg_idx, reg_val);
endinterface

// ===== verilog/mbws_store.sv
// Purpose: coil and holding register storage
// Assumes: indices are zero-based frame addresses
// Notes: writes beyond the storage size are dropped silently
`timescale 1ns/10ps
`include "mbws_params.svh"
module mbws_store #(
    parameter int NCOIL = 64,
    parameter int NREG = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    mbws_wr_if.dst wr,
    output logic [NCOIL-1:0] coil_o,
    input wire logic [15:0] reg_rd_idx_i,
    output logic [15:0] reg_rd_data_o
);
    import mbws_pkg::*;

    typedef struct packed {
        logic [NCOIL-1:0] coils;
        logic [NREG-1:0][15:0] regs;
        logic [15:0] rd;
    } mbws_store_t;

    mbws_store_t q, d;

    // coils are taken bit by bit, lowest bit to lowest coil
    always_comb begin
        int idx;
        idx = 0;
        d = q;
        if (wr.coil_we) begin
            for (int k = 0; k < 8; k++) begin
                idx = int'(wr.coil_base) + k;
                if (k < int'(wr.coil_n) && idx < NCOIL) begin
                    d.coils[idx] = wr.coil_byte[k]; // [RQ4]
                end
            end
        end
        if (wr.reg_we && int'(wr.reg_idx) < NREG) begin
            d.regs[wr.reg_idx] = wr.reg_val; // [RQ8]
        end
        d.rd = (int'(reg_rd_idx_i) < NREG) ? q.regs[reg_rd_idx_i] : `MBWS_RST_REG;
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign coil_o = q.coils;
    assign reg_rd_data_o = q.rd;
endmodule

// ===== verilog/mbws_top.sv
// Purpose: slave request handler for write coils, write registers, write one register
// Assumes: a framing layer delivers every frame byte, crc included, and flags the end
// Notes: replies to 0f/10 leave the crc to the framing layer (tx_crc_o high)
// Operation
// RQ1: master sends single register write fields
// RQ2: single register write answered by exact echo
// RQ3: coil write frame fields in fixed order
// RQ4: coil bytes land ascending from start coil
// RQ5: coil reply carries header, no state data
// RQ6: register write frame fields in fixed order
// RQ7: register values high byte first, consecutive
// RQ8: frame address zero is first reference
// RQ9: register reply omits written data
`timescale 1ns/10ps
`include "mbws_params.svh"
module mbws_top #(
    parameter int NCOIL = 64,
    parameter int NREG = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] slave_addr_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_end_i,
    input wire logic rx_crc_ok_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    output logic tx_crc_o,
    input wire logic tx_ready_i,
    output logic [NCOIL-1:0] coil_o,
    input wire logic [15:0] reg_rd_idx_i,
    output logic [15:0] reg_rd_data_o
);
    import mbws_pkg::*;

    // whole state of the handler, registered as one word
    typedef struct packed {
        mbws_state_t st;
        logic [7:0][7:0] frm;
        logic [15:0] cnt;
        logic [7:0] hi;
        logic [2:0] tx_idx;
        logic [2:0] tx_last;
        logic [7:0] txd;
        logic app_crc;
        logic coil_we;
        logic [15:0] coil_base;
        logic [7:0] coil_byte;
        logic [3:0] coil_n;
        logic reg_we;
        logic [15:0] reg_idx;
        logic [15:0] reg_val;
    } mbws_top_t;

    // idle state code is not all zeros, so reset needs its own constant
    localparam mbws_top_t RST_Q = '{st: MBWS_IDLE, default: '0};

    mbws_top_t q, d;

    // write strobes towards the storage
    mbws_wr_if wr_bus ();

    // byte counter sits on a given frame offset
    function automatic logic is_ofs(input logic [15:0] c, input logic [3:0] o);
        return c == {12'h000, o};
    endfunction

    // one of the three write functions this block answers
    function automatic logic fc_known(input logic [7:0] f);
        return (f == `MBWS_FC_WR_REG) || (f == `MBWS_FC_WR_COILS) ||
            (f == `MBWS_FC_WR_REGS);
    endfunction

    // next state: parse bytes, raise write strobes, send reply
    // limitation: multi writes land as the bytes come, before the crc
    // verdict; a bad frame gets no reply but may have written storage
    always_comb begin
        logic [7:0] b;
        logic [7:0] fc;
        logic [15:0] j;
        logic [15:0] rem;
        logic [15:0] start;
        logic good;
        b = rx_data_i;
        fc = q.frm[3'(`MBWS_OFS_FC)];
        j = q.cnt - {12'h000, `MBWS_OFS_DATA};
        rem = 16'h0000;
        start = {q.frm[2], q.frm[3]};
        good = 1'b0;
        d = q;
        d.coil_we = 1'b0;
        d.reg_we = 1'b0;
        case (q.st)
            MBWS_IDLE: begin
                // first byte is the slave address; others' frames are skipped
                if (rx_valid_i && !rx_end_i) begin
                    d.frm[0] = b;
                    d.cnt = 16'h0001;
                    d.st = (b == slave_addr_i) ? MBWS_RECV : MBWS_DROP;
                end
            end
            MBWS_RECV: begin
                if (rx_valid_i) begin
                    // first eight bytes kept for the reply [RQ3] [RQ6]
                    if (q.cnt[15:3] == 13'h0000) begin
                        d.frm[q.cnt[2:0]] = b;
                    end
                    if (q.cnt != 16'hffff) begin
                        d.cnt = q.cnt + 16'h0001;
                    end
                    // unknown function: swallow the rest of the frame
                    if (is_ofs(q.cnt, `MBWS_OFS_FC) && !fc_known(b)) begin
                        d.st = MBWS_DROP;
                    end
                    // data bytes of the multi writes, up to the byte count
                    if (q.cnt >= {12'h000, `MBWS_OFS_DATA} &&
                        j < {8'h00, q.frm[3'(`MBWS_OFS_BCNT)]}) begin
                        if (fc == `MBWS_FC_WR_COILS) begin
                            // eight coils per byte, byte j starts 8j coils after the start coil [RQ4] [RQ8]
                            rem = {q.frm[4], q.frm[5]} - {j[12:0], 3'b000};
                            if (rem != 16'h0000) begin
                                d.coil_we = 1'b1;
                                d.coil_base = start + {j[12:0], 3'b000};
                                d.coil_byte = b;
                                d.coil_n = (rem > `MBWS_COILS_PER_BYTE) ?
                                    4'(`MBWS_COILS_PER_BYTE) : rem[3:0];
                            end
                        end else if (fc == `MBWS_FC_WR_REGS) begin
                            // high byte first, one register per pair [RQ7] [RQ8]
                            if (!j[0]) begin
                                d.hi = b;
                            end else begin
                                d.reg_we = 1'b1;
                                d.reg_idx = start + {1'b0, j[15:1]};
                                d.reg_val = {q.hi, b};
                            end
                        end
                    end
                    // frame end: length and crc decide whether to answer
                    if (rx_end_i) begin
                        if (fc == `MBWS_FC_WR_REG) begin
                            good = is_ofs(q.cnt, `MBWS_ECHO_LEN - 4'h1);
                        end else begin
                            good = fc_known(fc) && (q.cnt ==
                                {8'h00, q.frm[3'(`MBWS_OFS_BCNT)]} +
                                {12'h000, `MBWS_OFS_DATA} + 16'h0001);
                        end
                        if (good && rx_crc_ok_i) begin
                            d.st = MBWS_RESP;
                            d.tx_idx = 3'h0;
                            d.txd = q.frm[0];
                            if (fc == `MBWS_FC_WR_REG) begin
                                // single write waits for the crc, then echoes [RQ2]
                                d.tx_last = 3'(`MBWS_ECHO_LEN - 4'h1);
                                d.app_crc = 1'b0;
                                d.reg_we = 1'b1;
                                d.reg_idx = start;
                                d.reg_val = {q.frm[4], q.frm[5]};
                            end else begin
                                // header only, crc added by framing [RQ5] [RQ9]
                                d.tx_last = 3'(`MBWS_HDR_LEN - 4'h1);
                                d.app_crc = 1'b1;
                            end
                        end else begin
                            d.st = MBWS_IDLE;
                        end
                    end
                end
            end
            MBWS_DROP: begin
                if (rx_valid_i && rx_end_i) begin
                    d.st = MBWS_IDLE;
                end
            end
            MBWS_RESP: begin
                // half duplex: bytes arriving now are ignored
                if (tx_ready_i) begin
                    if (q.tx_idx == q.tx_last) begin
                        d.st = MBWS_IDLE;
                    end else begin
                        d.tx_idx = q.tx_idx + 3'h1;
                        d.txd = q.frm[d.tx_idx];
                    end
                end
            end
            default: begin
                d = RST_Q;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= RST_Q;
        end else begin
            q <= d;
        end
    end

    // reply side; valid and last are plain decodes of the state
    assign tx_valid_o = (q.st == MBWS_RESP);
    assign tx_data_o = q.txd;
    assign tx_last_o = (q.st == MBWS_RESP) && (q.tx_idx == q.tx_last);
    assign tx_crc_o = (q.st == MBWS_RESP) && q.app_crc;

    // strobes are registered, so storage sees them one cycle late
    assign wr_bus.coil_we = q.coil_we;
    assign wr_bus.coil_base = q.coil_base;
    assign wr_bus.coil_byte = q.coil_byte;
    assign wr_bus.coil_n = q.coil_n;
    assign wr_bus.reg_we = q.reg_we;
    assign wr_bus.reg_idx = q.reg_idx;
    assign wr_bus.reg_val = q.reg_val;

    // coil and register storage
    mbws_store #(
        .NCOIL(NCOIL),
        .NREG(NREG)
    ) u_mbws_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr(wr_bus),
        .coil_o(coil_o),
        .reg_rd_idx_i(reg_rd_idx_i),
        .reg_rd_data_o(reg_rd_data_o)
    );

    // reply just started
    sequence s_resp_enter;
        (q.st != MBWS_RESP) ##1 (q.st == MBWS_RESP);
    endsequence

    // single write: whole request comes back, crc included
    property p_echo_whole;
        @(posedge clk_i) disable iff (rst_i)
        s_resp_enter ##0 (q.frm[1] == `MBWS_FC_WR_REG) |->
            (q.tx_last == 3'(`MBWS_ECHO_LEN - 4'h1)) && !tx_crc_o;
    endproperty
    a_echo_whole: assert property (p_echo_whole) // [RQ2]
        else $error("single write reply is not a full echo");

    // multi writes: six header bytes, crc from framing
    property p_hdr_reply;
        @(posedge clk_i) disable iff (rst_i)
        s_resp_enter ##0 (q.frm[1] != `MBWS_FC_WR_REG) |->
            (q.tx_last == 3'(`MBWS_HDR_LEN - 4'h1)) && tx_crc_o;
    endproperty
    a_hdr_reply: assert property (p_hdr_reply) // [RQ5] [RQ9]
        else $error("multi write reply length wrong");

    // reply opens with the slave address
    property p_first_byte;
        @(posedge clk_i) disable iff (rst_i)
        s_resp_enter |-> (tx_data_o == q.frm[0]) && (tx_data_o == slave_addr_i);
    endproperty
    a_first_byte: assert property (p_first_byte) // [RQ2]
        else $error("reply does not start with slave address");

    // taken last byte ends the reply
    property p_ends_idle;
        @(posedge clk_i) disable iff (rst_i)
        tx_valid_o && tx_ready_i && tx_last_o |=> (q.st == MBWS_IDLE);
    endproperty
    a_ends_idle: assert property (p_ends_idle) // [RQ5]
        else $error("reply runs past its last byte");

    // a coil strobe covers one to eight coils
    property p_coil_count;
        @(posedge clk_i) disable iff (rst_i)
        q.coil_we |-> (q.coil_n != 4'h0) && (q.coil_n <= 4'h8);
    endproperty
    a_coil_count: assert property (p_coil_count) // [RQ4]
        else $error("coil strobe count out of range");

    // register value pairs the held high byte with the new low byte
    property p_reg_pair;
        @(posedge clk_i) disable iff (rst_i)
        q.reg_we && (q.frm[1] == `MBWS_FC_WR_REGS) |->
            (q.reg_val[7:0] == $past(rx_data_i)) && (q.reg_val[15:8] == $past(q.hi));
    endproperty
    a_reg_pair: assert property (p_reg_pair) // [RQ7]
        else $error("register value byte order wrong");

    // a skipped frame is left at its end byte
    property p_drop_end;
        @(posedge clk_i) disable iff (rst_i)
        (q.st == MBWS_DROP) && rx_valid_i && rx_end_i |=> (q.st == MBWS_IDLE);
    endproperty
    a_drop_end: assert property (p_drop_end) // [RQ3]
        else $error("skipped frame not left at its end");
endmodule

// ===== test/mbws_master.sv
// Purpose: serial master stand-in
// Assumes: handler takes one byte per valid cycle
// Notes: reply bytes gather in rep
`timescale 1ns/10ps
module mbws_master (
    input wire logic clk_i,
    output logic rx_valid_o = 1'b0,
    output logic [7:0] rx_data_o = 8'h00,
    output logic rx_end_o = 1'b0,
    output logic rx_crc_ok_o = 1'b0,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o = 1'b1
);
    logic [63:0] rep = 64'h0;
    int n_rep = 0;
    // whole frame, crc bytes last
    task automatic send(input logic [127:0] f, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= f[8*i+:8];
            rx_end_o <= (i == 0);
            rx_crc_ok_o <= (i == 0);
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_end_o <= 1'b0;
        rx_data_o <= ~rx_data_o; // idle line must not look like data
    endtask
    // collect reply bytes
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            rep <= {rep[55:0], tx_data_i};
            n_rep <= n_rep + 1;
        end
    end
endmodule

// ===== test/mbws_top_bench.sv
// Purpose: bench of the write request handler
// Assumes: crc bytes are dummies
// Notes: one task each for the coil and register frames; single write frames go straight through run
`timescale 1ns/10ps
module mbws_top_bench;
    logic clk_i = 0, rst_i = 1, rv, re, rc, tv, tl, tr, tc, cf = 0;
    int nl = 0;
    logic [7:0] rd, td;
    logic [63:0] co;
    logic [15:0] ri = 16'h0000, rr;
    int miscompares = 0, total_checks = 0, cyc = 0;
    initial forever #25 clk_i = ~clk_i;
    mbws_top u_mbws_top (.clk_i(clk_i), .rst_i(rst_i), .slave_addr_i(8'h11), .rx_valid_i(rv),
        .rx_data_i(rd), .rx_end_i(re), .rx_crc_ok_i(rc), .tx_valid_o(tv), .tx_data_o(td),
        .tx_last_o(tl), .tx_crc_o(tc), .tx_ready_i(tr), .coil_o(co), .reg_rd_idx_i(ri),
        .reg_rd_data_o(rr));
    mbws_master u_mbws_master (.clk_i(clk_i), .rx_valid_o(rv), .rx_data_o(rd), .rx_end_o(re),
        .rx_crc_ok_o(rc), .tx_valid_i(tv), .tx_data_i(td), .tx_ready_o(tr));
    task automatic chk(string s, logic [63:0] e, logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    // send a frame, then judge reply bytes and count
    task automatic run(logic [127:0] f, int n, logic [63:0] r, int m);
        u_mbws_master.rep = 64'h0;
        u_mbws_master.n_rep = 0;
        nl = 0;
        u_mbws_master.send(f, n);
        repeat (40) @(posedge clk_i);
        chk("reply", r, u_mbws_master.rep);
        chk("reply bytes", m, u_mbws_master.n_rep);
        chk("last flags", (m > 0) ? 1 : 0, nl);
        if (m > 0) chk("crc flag", (m == 6) ? 1 : 0, cf);
    endtask
    // last and crc flags of taken reply bytes
    always @(posedge clk_i) begin
        if (tv && tr) begin
            if (tl) nl <= nl + 1;
            cf <= tc;
        end
    end
    task automatic t_coils;
        run(88'h110f0013000a02cd005aa5, 11, 48'h110f0013000a, 6);
        chk("coils", 64'h00cd, co[28:19]);
    endtask
    task automatic t_regs;
        run(104'h111000070002040105_0a105aa5, 13, 48'h111000070002, 6);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            ri <= 16'h0007 + 16'(i);
            repeat (2) @(posedge clk_i);
            chk("reg", i ? 64'h0a10 : 64'h0105, rr);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_coils();
        run(64'h22060003039ec1c2, 8, 64'h0, 0);
        t_regs();
        run(64'h11060003039ec1c2, 8, 64'h11060003039ec1c2, 8);
        end_sim();
    end
endmodule
